// [logic/crf_regfile.sv]
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module crf_regfile
#(
   parameter int unsigned ADDR_W = 8
)
(
   // clock, reset, enable
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_clk_en,
   // apb slave
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [ADDR_W-1:0]    i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic      [31:0]          o_prdata,
   output logic                      o_pready,
   output logic                      o_pslverr,
   // core write and read port
   input  wire logic                 i_core_wr,
   input  wire crf_pkg::crf_sel_t    i_core_wsel,
   input  wire crf_pkg::crf_size_t   i_core_wsize,
   input  wire logic [31:0]          i_core_wdata,
   input  wire crf_pkg::crf_sel_t    i_core_rsel,
   input  wire crf_pkg::crf_size_t   i_core_rsize,
   output logic      [31:0]          o_core_rdata,
   // alu flag update
   input  wire logic                 i_flag_upd,
   input  wire logic [15:0]          i_alu_result,
   input  wire logic                 i_alu_carry,
   input  wire logic                 i_alu_ovf,
   // sequencer: program counter and stack
   input  wire logic                 i_pc_load,
   input  wire logic [19:0]          i_pc_value,
   input  wire logic                 i_pc_adv,
   input  wire logic [3:0]           i_pc_step,
   input  wire logic                 i_sp_wr,
   input  wire logic [15:0]          i_sp_value,
   // state seen by the core
   output logic      [19:0]          o_pc,
   output logic      [19:0]          o_vector_base,
   output logic      [15:0]          o_static_base,
   output logic      [15:0]          o_frame_base,
   output logic      [15:0]          o_stack_ptr,
   output logic      [10:0]          o_flags
);
   import crf_pkg::*;

   // the decode compares a full byte offset, so fewer than 8 address bits cannot work
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_bad_addr
      $error("crf_regfile: ADDR_W must lie between 8 and 32");
   end

   // storage
   logic [15:0] data_r [CRF_BANKS][4];
   logic [15:0] addr_r [CRF_BANKS][2];
   logic [15:0] fb_r   [CRF_BANKS];
   logic [15:0] sb_r;
   logic [19:0] vector_table_base_r;
   logic [19:0] pc_r;
   logic [15:0] usp_r;
   logic [15:0] isp_r;
   logic [10:0] flag_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] core_rdata_r;
   logic [15:0] fb_mirror_r;
   logic [15:0] sp_mirror_r;

   logic        bank;
   logic        apb_busy;
   logic        apb_go;
   logic        apb_hit;
   crf_sel_t    apb_sel;
   crf_size_t   apb_size;
   logic        w_en;
   crf_sel_t    w_sel;
   crf_size_t   w_size;
   logic [31:0] w_data;

   assign bank = flag_r[CRF_FLG_BANK];

   // read mux shared by apb and core; always the selected bank
   function automatic logic [31:0] rd_val(input crf_sel_t s, input crf_size_t z,
                                          input logic b);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (s)
         CRF_SEL_DATA0  : v = (z == CRF_SZ_LONG) ? {data_r[b][2], data_r[b][0]}
                            : (z == CRF_SZ_HI) ? {24'h00_0000, data_r[b][0][15:8]}
                            : (z == CRF_SZ_LO) ? {24'h00_0000, data_r[b][0][7:0]}
                            : {16'h0000, data_r[b][0]};
         CRF_SEL_DATA1  : v = (z == CRF_SZ_LONG) ? {data_r[b][3], data_r[b][1]}
                            : (z == CRF_SZ_HI) ? {24'h00_0000, data_r[b][1][15:8]}
                            : (z == CRF_SZ_LO) ? {24'h00_0000, data_r[b][1][7:0]}
                            : {16'h0000, data_r[b][1]};
         CRF_SEL_DATA2  : v = {16'h0000, data_r[b][2]};
         CRF_SEL_DATA3  : v = {16'h0000, data_r[b][3]};
         CRF_SEL_ADDR0  : v = (z == CRF_SZ_LONG) ? {addr_r[b][1], addr_r[b][0]}
                            : {16'h0000, addr_r[b][0]};
         CRF_SEL_ADDR1  : v = {16'h0000, addr_r[b][1]};
         CRF_SEL_FRAME  : v = {16'h0000, fb_r[b]};
         CRF_SEL_STATIC : v = {16'h0000, sb_r};
         CRF_SEL_VECTOR : v = {12'h000, vector_table_base_r};
         CRF_SEL_PC     : v = {12'h000, pc_r};
         CRF_SEL_USP    : v = {16'h0000, usp_r};
         CRF_SEL_ISP    : v = {16'h0000, isp_r};
         CRF_SEL_FLAG   : v = {21'h00_0000, flag_r};
         default        : v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // apb address decode; unaligned or unmapped gives an error answer
   always_comb
   begin
      apb_hit  = 1'b1;
      apb_sel  = CRF_SEL_NONE;
      apb_size = CRF_SZ_WORD;
      if (i_paddr[1:0] != 2'b00 || i_paddr[ADDR_W-1:6] != '0)
         apb_hit = 1'b0;
      else if (i_paddr[7:0] == CRF_OFF_DATA0)
         apb_sel = CRF_SEL_DATA0;
      else if (i_paddr[7:0] == CRF_OFF_DATA1)
         apb_sel = CRF_SEL_DATA1;
      else if (i_paddr[7:0] == CRF_OFF_DATA2)
         apb_sel = CRF_SEL_DATA2;
      else if (i_paddr[7:0] == CRF_OFF_DATA3)
         apb_sel = CRF_SEL_DATA3;
      else if (i_paddr[7:0] == CRF_OFF_ADDR0)
         apb_sel = CRF_SEL_ADDR0;
      else if (i_paddr[7:0] == CRF_OFF_ADDR1)
         apb_sel = CRF_SEL_ADDR1;
      else if (i_paddr[7:0] == CRF_OFF_FRAME)
         apb_sel = CRF_SEL_FRAME;
      else if (i_paddr[7:0] == CRF_OFF_STATIC)
         apb_sel = CRF_SEL_STATIC;
      else if (i_paddr[7:0] == CRF_OFF_VECTOR)
         apb_sel = CRF_SEL_VECTOR;
      else if (i_paddr[7:0] == CRF_OFF_PC)
         apb_sel = CRF_SEL_PC;
      else if (i_paddr[7:0] == CRF_OFF_USP)
         apb_sel = CRF_SEL_USP;
      else if (i_paddr[7:0] == CRF_OFF_ISP)
         apb_sel = CRF_SEL_ISP;
      else if (i_paddr[7:0] == CRF_OFF_FLAG)
         apb_sel = CRF_SEL_FLAG;
      else if (i_paddr[7:0] == CRF_OFF_LONG_DLO)
      begin
         apb_sel  = CRF_SEL_DATA0;
         apb_size = CRF_SZ_LONG;
      end
      else if (i_paddr[7:0] == CRF_OFF_LONG_DHI)
      begin
         apb_sel  = CRF_SEL_DATA1;
         apb_size = CRF_SZ_LONG;
      end
      else if (i_paddr[7:0] == CRF_OFF_LONG_ADDR)
      begin
         apb_sel  = CRF_SEL_ADDR0;
         apb_size = CRF_SZ_LONG;
      end
      else
         apb_hit = 1'b0;
   end

   // apb waits out any core update, so hardware events are never overwritten
   assign apb_busy = i_core_wr | i_flag_upd | i_pc_load | i_pc_adv | i_sp_wr;
   assign apb_go   = i_psel & i_penable & ~pready_r & ~apb_busy;

   // one write path: core first, apb only when the core is quiet
   always_comb
   begin
      w_en   = 1'b0;
      w_sel  = CRF_SEL_NONE;
      w_size = CRF_SZ_WORD;
      w_data = 32'h0000_0000;
      if (i_core_wr)
      begin
         w_en   = 1'b1;
         w_sel  = i_core_wsel;
         w_size = i_core_wsize;
         w_data = i_core_wdata;
      end
      else if (apb_go && i_pwrite && apb_hit)
      begin
         w_en   = 1'b1;
         w_sel  = apb_sel;
         w_size = apb_size;
         w_data = i_pwdata;
      end
   end

   // apb answer: pready is a one-cycle pulse, data registered with it
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else if (i_clk_en)
      begin
         pready_r <= apb_go;
         if (apb_go)
         begin
            pslverr_r <= ~apb_hit;
            prdata_r  <= (apb_hit && !i_pwrite) ? rd_val(apb_sel, apb_size, bank)
                                                : 32'h0000_0000;
         end
      end
   end

   // banked registers; byte sizes only act on the first two data words
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int b = 0; b < CRF_BANKS; b++)
         begin
            for (int k = 0; k < 4; k++)
               data_r[b][k] <= CRF_RST_WORD;
            addr_r[b][0] <= CRF_RST_WORD;
            addr_r[b][1] <= CRF_RST_WORD;
            fb_r[b]      <= CRF_RST_WORD;
         end
      end
      else if (i_clk_en && w_en)
      begin
         case (w_sel)
            CRF_SEL_DATA0, CRF_SEL_DATA1 :
            begin
               case (w_size)
                  CRF_SZ_LO   : data_r[bank][w_sel[0]][7:0]  <= w_data[7:0];
                  CRF_SZ_HI   : data_r[bank][w_sel[0]][15:8] <= w_data[7:0];
                  CRF_SZ_WORD : data_r[bank][w_sel[0]]       <= w_data[15:0];
                  default     :
                  begin
                     data_r[bank][w_sel[0]]                <= w_data[15:0];
                     data_r[bank][{1'b1, w_sel[0]}]        <= w_data[31:16];
                  end
               endcase
            end
            CRF_SEL_DATA2 : data_r[bank][2] <= w_data[15:0];
            CRF_SEL_DATA3 : data_r[bank][3] <= w_data[15:0];
            CRF_SEL_ADDR0 :
            begin
               addr_r[bank][0] <= w_data[15:0];
               if (w_size == CRF_SZ_LONG)
                  addr_r[bank][1] <= w_data[31:16];
            end
            CRF_SEL_ADDR1 : addr_r[bank][1] <= w_data[15:0];
            CRF_SEL_FRAME : fb_r[bank]      <= w_data[15:0];
            default       : ;
         endcase
      end
   end

   // static base and vector table base
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sb_r   <= CRF_RST_WORD;
         vector_table_base_r <= CRF_RST_PC;
      end
      else if (i_clk_en && w_en)
      begin
         if (w_sel == CRF_SEL_STATIC)
            sb_r <= w_data[15:0];
         if (w_sel == CRF_SEL_VECTOR)
            vector_table_base_r <= w_data[19:0];
      end
   end

   // program counter: load beats advance beats a plain write
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         pc_r <= CRF_RST_PC;
      else if (i_clk_en)
      begin
         if (i_pc_load)
            pc_r <= i_pc_value;
         else if (i_pc_adv)
            pc_r <= pc_r + {16'h0000, i_pc_step};
         else if (w_en && w_sel == CRF_SEL_PC)
            pc_r <= w_data[19:0];
      end
   end

   // stack pointers; the sequencer's write goes to the active one
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         usp_r <= CRF_RST_WORD;
         isp_r <= CRF_RST_WORD;
      end
      else if (i_clk_en)
      begin
         if (w_en && w_sel == CRF_SEL_USP)
            usp_r <= w_data[15:0];
         if (w_en && w_sel == CRF_SEL_ISP)
            isp_r <= w_data[15:0];
         if (i_sp_wr && flag_r[CRF_FLG_USTK])
            usp_r <= i_sp_value;
         else if (i_sp_wr)
            isp_r <= i_sp_value;
      end
   end

   // flag word: alu result wins over a write in the same cycle
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         flag_r <= CRF_RST_FLAG;
      else if (i_clk_en)
      begin
         if (w_en && w_sel == CRF_SEL_FLAG)
            flag_r <= w_data[10:0];
         if (i_flag_upd)
         begin
            flag_r[CRF_FLG_CARRY] <= i_alu_carry;
            flag_r[CRF_FLG_ZERO]  <= (i_alu_result == 16'h0000);
            flag_r[CRF_FLG_SIGN]  <= i_alu_result[15];
            flag_r[CRF_FLG_OVF]   <= i_alu_ovf;
         end
      end
   end

   // core read and mirrors; registered, so they trail the state by a cycle
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         core_rdata_r <= 32'h0000_0000;
         fb_mirror_r  <= CRF_RST_WORD;
         sp_mirror_r  <= CRF_RST_WORD;
      end
      else if (i_clk_en)
      begin
         core_rdata_r <= rd_val(i_core_rsel, i_core_rsize, bank);
         fb_mirror_r  <= fb_r[bank];
         sp_mirror_r  <= flag_r[CRF_FLG_USTK] ? usp_r : isp_r;
      end
   end

   assign o_prdata      = prdata_r;
   assign o_pready      = pready_r;
   assign o_pslverr     = pslverr_r;
   assign o_core_rdata  = core_rdata_r;
   assign o_pc          = pc_r;
   assign o_vector_base = vector_table_base_r;
   assign o_static_base = sb_r;
   assign o_frame_base  = fb_mirror_r;
   assign o_stack_ptr   = sp_mirror_r;
   assign o_flags       = flag_r;

   // helpers read only by the checks below
   logic [15:0] cur_d0;
   logic [15:0] oth_d2;
   assign cur_d0 = data_r[bank][0];
   assign oth_d2 = data_r[~bank][2];

   property p_byte_keep;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && w_en && w_sel == CRF_SEL_DATA0 && w_size == CRF_SZ_LO)
      |=> (data_r[$past(bank)][0] == {$past(cur_d0[15:8]), $past(w_data[7:0])});
   endproperty
   a_byte_keep : assert property (p_byte_keep)
      else $error("byte write disturbed other half");

   property p_long_data;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && w_en && w_sel == CRF_SEL_DATA1 && w_size == CRF_SZ_LONG)
      |=> (data_r[$past(bank)][3] == $past(w_data[31:16]))
          && (data_r[$past(bank)][1] == $past(w_data[15:0]));
   endproperty
   a_long_data : assert property (p_long_data)
      else $error("long data pair not split correctly");

   property p_long_addr;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && w_en && w_sel == CRF_SEL_ADDR0 && w_size == CRF_SZ_LONG)
      |=> (addr_r[$past(bank)][1] == $past(w_data[31:16]));
   endproperty
   a_long_addr : assert property (p_long_addr)
      else $error("long address upper word wrong");

   property p_sp_select;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && !i_sp_wr && !w_en)
      |=> (o_stack_ptr == ($past(flag_r[CRF_FLG_USTK]) ? $past(usp_r) : $past(isp_r)));
   endproperty
   a_sp_select : assert property (p_sp_select)
      else $error("stack pointer output ignores select flag");

   property p_zero_sign;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_flag_upd)
      |=> (flag_r[CRF_FLG_ZERO] == ($past(i_alu_result) == 16'h0000))
          && (flag_r[CRF_FLG_SIGN] == $past(i_alu_result[15]));
   endproperty
   a_zero_sign : assert property (p_zero_sign)
      else $error("zero or sign flag wrong");

   property p_carry_ovf;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_flag_upd)
      |=> (flag_r[CRF_FLG_CARRY] == $past(i_alu_carry))
          && (flag_r[CRF_FLG_OVF] == $past(i_alu_ovf));
   endproperty
   a_carry_ovf : assert property (p_carry_ovf)
      else $error("carry or overflow flag not captured");

   property p_bank_apart;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && w_en && w_sel == CRF_SEL_DATA2) |=> $stable(oth_d2);
   endproperty
   a_bank_apart : assert property (p_bank_apart)
      else $error("write leaked into the other bank");

   property p_pc_load;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_pc_load) |=> (o_pc == $past(i_pc_value));
   endproperty
   a_pc_load : assert property (p_pc_load)
      else $error("program counter load lost");

   property p_apb_pulse;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_clk_en && i_psel && i_penable && !o_pready && !apb_busy)
      |=> o_pready ##1 (!o_pready || !$past(i_clk_en));
   endproperty
   a_apb_pulse : assert property (p_apb_pulse)
      else $error("apb ready not a single pulse");

   c_long_write : cover property (@(posedge i_ref_clk) disable iff (i_rst)
      (w_en && w_size == CRF_SZ_LONG));
   c_bank_swap  : cover property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(bank));
   c_apb_stall  : cover property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_psel && i_penable && apb_busy));
   c_flag_clash : cover property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_flag_upd && w_en && w_sel == CRF_SEL_FLAG));
endmodule

// [logic/crf_pkg.sv]
package crf_pkg;
   // storage widths
   localparam int unsigned CRF_WORD_W = 16;
   localparam int unsigned CRF_PC_W   = 20;
   localparam int unsigned CRF_FLAG_W = 11;
   localparam int unsigned CRF_BANKS  = 2;

   // apb byte offsets, one aligned word each
   localparam logic [7:0] CRF_OFF_DATA0     = 8'h00;
   localparam logic [7:0] CRF_OFF_DATA1     = 8'h04;
   localparam logic [7:0] CRF_OFF_DATA2     = 8'h08;
   localparam logic [7:0] CRF_OFF_DATA3     = 8'h0C;
   localparam logic [7:0] CRF_OFF_ADDR0     = 8'h10;
   localparam logic [7:0] CRF_OFF_ADDR1     = 8'h14;
   localparam logic [7:0] CRF_OFF_FRAME     = 8'h18;
   localparam logic [7:0] CRF_OFF_STATIC    = 8'h1C;
   localparam logic [7:0] CRF_OFF_VECTOR    = 8'h20;
   localparam logic [7:0] CRF_OFF_PC        = 8'h24;
   localparam logic [7:0] CRF_OFF_USP       = 8'h28;
   localparam logic [7:0] CRF_OFF_ISP       = 8'h2C;
   localparam logic [7:0] CRF_OFF_FLAG      = 8'h30;
   localparam logic [7:0] CRF_OFF_LONG_DLO  = 8'h34;
   localparam logic [7:0] CRF_OFF_LONG_DHI  = 8'h38;
   localparam logic [7:0] CRF_OFF_LONG_ADDR = 8'h3C;

   // flag word field positions
   localparam int unsigned CRF_FLG_CARRY = 0;
   localparam int unsigned CRF_FLG_DEBUG = 1;
   localparam int unsigned CRF_FLG_ZERO  = 2;
   localparam int unsigned CRF_FLG_SIGN  = 3;
   localparam int unsigned CRF_FLG_BANK  = 4;
   localparam int unsigned CRF_FLG_OVF   = 5;
   localparam int unsigned CRF_FLG_USTK  = 7;

   // values after reset
   localparam logic [15:0] CRF_RST_WORD = 16'h0000;
   localparam logic [19:0] CRF_RST_PC   = 20'h0_0000;
   localparam logic [10:0] CRF_RST_FLAG = 11'h000;

   // register selector for both write paths and the core read port
   typedef enum logic [3:0] {
      CRF_SEL_DATA0, CRF_SEL_DATA1, CRF_SEL_DATA2, CRF_SEL_DATA3,
      CRF_SEL_ADDR0, CRF_SEL_ADDR1, CRF_SEL_FRAME, CRF_SEL_STATIC,
      CRF_SEL_VECTOR, CRF_SEL_PC, CRF_SEL_USP, CRF_SEL_ISP,
      CRF_SEL_FLAG, CRF_SEL_NONE
   } crf_sel_t;

   // access size
   typedef enum logic [1:0] {
      CRF_SZ_LO, CRF_SZ_HI, CRF_SZ_WORD, CRF_SZ_LONG
   } crf_size_t;
endpackage

// [sim/crf_core_model.sv]
`timescale 1ns/100ps
// sequencer and alu stand-in: at most one strobe per call (rd drives none), data lines scrambled when idle
module crf_core_model
(
   // clock
   input  wire logic            i_clk,
   // core side of the register file
   output logic                 o_wr,
   output crf_pkg::crf_sel_t    o_wsel,
   output crf_pkg::crf_size_t   o_wsize,
   output logic [31:0]          o_wdata,
   output crf_pkg::crf_sel_t    o_rsel,
   output crf_pkg::crf_size_t   o_rsize,
   output logic                 o_fupd,
   output logic [15:0]          o_res,
   output logic                 o_cy,
   output logic                 o_ov,
   output logic                 o_pcl,
   output logic [19:0]          o_pcv,
   output logic                 o_pca,
   output logic [3:0]           o_pcs,
   output logic                 o_spw,
   output logic [15:0]          o_spv
);
   import crf_pkg::*;
   // idle: every strobe low
   initial
   begin
      {o_wr, o_fupd, o_pcl, o_pca, o_spw, o_cy, o_ov} = 7'h00;
      {o_wdata, o_res, o_pcv, o_pcs, o_spv} = 88'h0;
      o_wsel = CRF_SEL_NONE;
      o_wsize = CRF_SZ_WORD;
      o_rsel = CRF_SEL_DATA0;
      o_rsize = CRF_SZ_WORD;
   end
   // strobe seen at one edge only; stale data would hide a late capture
   task automatic fin();
      @(posedge i_clk);
      {o_wr, o_fupd, o_pcl, o_pca, o_spw} <= 5'h00;
      o_wdata <= ~o_wdata;
      o_res <= ~o_res;
      o_pcv <= ~o_pcv;
      o_spv <= ~o_spv;
   endtask
   // register write
   task automatic wr(input crf_sel_t s, input crf_size_t z, input logic [31:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_wsel <= s;
      o_wsize <= z;
      o_wdata <= (s == CRF_SEL_FLAG) ? (d & 32'hFFFF_FFFD) : d;
      fin();
   endtask
   // alu result for flag update
   task automatic alu(input logic [15:0] r, input logic c, input logic v);
      @(posedge i_clk);
      o_fupd <= 1'b1;
      o_res <= r;
      o_cy <= c;
      o_ov <= v;
      fin();
   endtask
   // pc load when l, else advance by s
   task automatic pc(input logic l, input logic [19:0] v, input logic [3:0] s);
      @(posedge i_clk);
      o_pcl <= l;
      o_pca <= ~l;
      o_pcv <= v;
      o_pcs <= s;
      fin();
   endtask
   // active stack pointer write
   task automatic sp(input logic [15:0] v);
      @(posedge i_clk);
      o_spw <= 1'b1;
      o_spv <= v;
      fin();
   endtask
   // read select, held until the next call
   task automatic rd(input crf_sel_t s, input crf_size_t z);
      @(posedge i_clk);
      o_rsel <= s;
      o_rsize <= z;
   endtask
endmodule

// [sim/tb_cpu_core_register_file.sv]
`timescale 1ns/100ps
module tb_cpu_core_register_file;
   import crf_pkg::*;
   logic        clk, rst, ce, psel, pen, pwr, rdy, err, ev, c_wr, c_fupd, c_cy, c_ov;
   logic        c_pcl, c_pca, c_spw;
   logic [7:0]  addr;
   logic [31:0] wd, rdat, crd, rv, v, c_wdata, ex[12];
   logic [19:0] c_pcv, pc, vb;
   logic [15:0] c_res, c_spv, sb, fb, sp, r16;
   logic [10:0] cpu_flag_word, f;
   logic [3:0]  c_pcs;
   logic [1:0]  b;
   crf_sel_t    c_wsel, c_rsel;
   crf_size_t   c_wsize, c_rsize;
   int          seed = 32'h1998_30fe;
   int          fails = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          lo[3] = '{0, 1, 4};
   int          hi[3] = '{2, 3, 5};

   crf_regfile crf_regfile_inst
   (
      .i_ref_clk(clk), .i_rst(rst), .i_clk_en(ce),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
      .i_pwdata(wd), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err),
      .i_core_wr(c_wr), .i_core_wsel(c_wsel), .i_core_wsize(c_wsize),
      .i_core_wdata(c_wdata), .i_core_rsel(c_rsel), .i_core_rsize(c_rsize),
      .o_core_rdata(crd), .i_flag_upd(c_fupd), .i_alu_result(c_res),
      .i_alu_carry(c_cy), .i_alu_ovf(c_ov), .i_pc_load(c_pcl), .i_pc_value(c_pcv),
      .i_pc_adv(c_pca), .i_pc_step(c_pcs), .i_sp_wr(c_spw), .i_sp_value(c_spv),
      .o_pc(pc), .o_vector_base(vb), .o_static_base(sb), .o_frame_base(fb),
      .o_stack_ptr(sp), .o_flags(cpu_flag_word)
   );
   crf_core_model crf_core_model_inst
   (
      .i_clk(clk), .o_wr(c_wr), .o_wsel(c_wsel), .o_wsize(c_wsize), .o_wdata(c_wdata),
      .o_rsel(c_rsel), .o_rsize(c_rsize), .o_fupd(c_fupd), .o_res(c_res), .o_cy(c_cy),
      .o_ov(c_ov), .o_pcl(c_pcl), .o_pcv(c_pcv), .o_pca(c_pca), .o_pcs(c_pcs),
      .o_spw(c_spw), .o_spv(c_spv)
   );

   // 25 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fails++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
         fails++;
      end
   endtask
   // apb transfer; pready sampled at the rising edge, answer taken at that same edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (rdy !== 1'b1);
      rv = rdat;
      ev = err;
      psel <= 1'b0;
      pen <= 1'b0;
      wd <= ~d;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rv, e);
   endtask
   task automatic st();
      @(posedge clk);
      @(negedge clk);
   endtask

   initial
   begin
      {rst, ce, psel, pen, pwr, addr, wd} = {5'h18, 40'h0};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // reset value, then random word written and read back, per register
      for (int i = 0; i < 12; i++)
      begin
         rdc(8'(i * 4), 32'h0000_0000);
         v = $random(seed);
         apb(1'b1, 8'(i * 4), v);
         ex[i] = v & ((i == 8 || i == 9) ? 32'h000F_FFFF : 32'h0000_FFFF);
         rdc(8'(i * 4), ex[i]);
      end
      rdc(CRF_OFF_FLAG, 32'h0000_0000);
      st();
      chk({12'h000, pc}, ex[9]);
      chk({12'h000, vb}, ex[8]);
      chk({16'h0000, sb}, ex[7]);
      chk({16'h0000, fb}, ex[6]);
      chk({16'h0000, sp}, ex[11]);
      $display("test words done");
      // long pairs: low register bits 15:0, partner bits 31:16
      for (int i = 0; i < 3; i++)
      begin
         v = $random(seed);
         apb(1'b1, 8'(52 + i * 4), v);
         ex[lo[i]] = {16'h0000, v[15:0]};
         ex[hi[i]] = {16'h0000, v[31:16]};
         rdc(8'(lo[i] * 4), ex[lo[i]]);
         rdc(8'(hi[i] * 4), ex[hi[i]]);
         rdc(8'(52 + i * 4), v);
      end
      // byte halves from the core port, the other half must survive
      v = $random(seed);
      crf_core_model_inst.wr(CRF_SEL_DATA0, CRF_SZ_HI, v);
      ex[0] = {16'h0000, v[7:0], ex[0][7:0]};
      crf_core_model_inst.wr(CRF_SEL_DATA1, CRF_SZ_LO, ~v);
      ex[1] = {16'h0000, ex[1][15:8], ~v[7:0]};
      crf_core_model_inst.rd(CRF_SEL_DATA0, CRF_SZ_WORD);
      st();
      chk(crd, ex[0]);
      rdc(CRF_OFF_DATA1, ex[1]);
      $display("test pairs done");
      // alu flags: zero, negative, then two random results
      for (int i = 0; i < 4; i++)
      begin
         r16 = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : 16'($random(seed));
         b = 2'($random(seed));
         crf_core_model_inst.alu(r16, b[0], b[1]);
         @(negedge clk);
         f = 11'h000;
         f[CRF_FLG_CARRY] = b[0];
         f[CRF_FLG_ZERO] = (r16 == 16'h0000);
         f[CRF_FLG_SIGN] = r16[15];
         f[CRF_FLG_OVF] = b[1];
         chk({21'h0, cpu_flag_word}, {21'h0, f});
      end
      // bank one keeps its own copy; user stack pointer chosen
      apb(1'b1, CRF_OFF_FLAG, 32'h0000_0090);
      rdc(CRF_OFF_DATA0, 32'h0000_0000);
      v = $random(seed);
      apb(1'b1, CRF_OFF_FRAME, v);
      st();
      chk({16'h0000, fb}, {16'h0000, v[15:0]});
      chk({16'h0000, sp}, ex[10]);
      crf_core_model_inst.sp(~v[15:0]);
      rdc(CRF_OFF_USP, {16'h0000, ~v[15:0]});
      apb(1'b1, CRF_OFF_FLAG, 32'h0000_0000);
      rdc(CRF_OFF_DATA0, ex[0]);
      st();
      chk({16'h0000, fb}, ex[6]);
      chk({16'h0000, sp}, ex[11]);
      $display("test banks done");
      // unmapped and unaligned places are refused and write nothing
      apb(1'b1, 8'h41, v);
      chk({31'h0, ev}, 32'h0000_0001);
      apb(1'b0, 8'h01, v);
      chk({31'h0, ev}, 32'h0000_0001);
      chk(rv, 32'h0000_0000);
      rdc(CRF_OFF_DATA0, ex[0]);
      // pc advance, then load
      crf_core_model_inst.pc(1'b0, 20'h0_0000, 4'h4);
      @(negedge clk);
      chk({12'h000, pc}, (ex[9] + 32'h0000_0004) & 32'h000F_FFFF);
      crf_core_model_inst.pc(1'b1, 20'hA_BCDE, 4'h0);
      @(negedge clk);
      chk({12'h000, pc}, 32'h000A_BCDE);
      // enable low freezes the counter, so this advance must be lost
      @(posedge clk);
      ce <= 1'b0;
      crf_core_model_inst.pc(1'b0, 20'h0_0000, 4'h4);
      ce <= 1'b1;
      @(negedge clk);
      chk({12'h000, pc}, 32'h000A_BCDE);
      $display("test refuse and pc done");
      report_and_stop();
   end
endmodule
